// File: inc/fsp_regs.vh
// Constants of the flash status poller: command register map, field positions, timing counts.
// Assumes a 50 MHz system clock and a 16-bit asynchronous NOR flash data bus.
// What this block does
// - Buffer program: poll the last loaded word
// - Poll at program address or erasing sector
// - Poll mode: final data from the first read whose whole low byte matches
// - Bracket each read with enable deassertion
// - Two reads compared; unchanged activity bit (bit 6) means finished
// - Toggling: check timeout bit, recheck, then flag failure
// - Resumed monitoring restarts from first step
// - No interleaved reads to other sectors
// - After timeout error, issue reset command when software sets the reset bit
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
`define FSP_REG_CTRL 4'h0
`define FSP_REG_ADDR 4'h1
`define FSP_REG_STAT 4'h2
`define FSP_REG_DATA 4'h3
`define FSP_REG_CNT 4'h4
`define FSP_CTRL_START 0
`define FSP_CTRL_MODE 1
`define FSP_CTRL_RESET 2
`define FSP_STAT_BUSY 0
`define FSP_STAT_DONE 1
`define FSP_STAT_FAIL 2
`define FSP_STAT_SUSP 3
`define FSP_STAT_RSTD 4
`define FSP_BIT_POLL 7
`define FSP_BIT_ACT 6
`define FSP_BIT_TOUT 5
`define FSP_BIT_SECT 2
`define FSP_RESET_CMD 16'h00F0
`define FSP_CLK_NS 20
`define FSP_RD_NS 100
`define FSP_RD_CYC ((`FSP_RD_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_GAP_NS 40
`define FSP_GAP_CYC ((`FSP_GAP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_STAT_RST 16'h0000
`endif

// File: verilog/fsp_status_poller.v
// Flash status poller: reads write-operation status from a NOR flash and decides completion.
// Assumes a flash with asynchronous read cycles whose data is settled after the read hold time.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "fsp_regs.vh"
module fsp_status_poller (
	input wire clk, // 50 MHz clock
	input wire sys_rst, // synchronous reset, active high
	input wire [3:0] reg_addr, // command register index
	input wire [31:0] reg_wdata, // command write data
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	output reg [31:0] reg_rdata, // read data, cycle after strobe
	output reg [24:0] flash_addr, // flash word address
	output reg [15:0] flash_dq_out, // data driven to flash
	output reg flash_dq_oe, // high while driving data
	input wire [15:0] flash_dq_in, // data from flash
	output reg flash_ce_n, // chip enable, active low
	output reg flash_oe_n, // output enable, active low
	output reg flash_we_n // write enable, active low
);
	localparam ST_IDLE = 3'd0;
	localparam ST_RD = 3'd1;
	localparam ST_GAP = 3'd2;
	localparam ST_EVAL = 3'd3;
	localparam ST_WR = 3'd4;
	localparam ST_FIN = 3'd5;

	reg [2:0] state;
	reg [7:0] cnt;
	reg mode_poll; // 1: complement polling, 0: toggle bits
	reg [7:0] expect_data; // true value of the low byte at the program address
	reg [24:0] poll_addr;
	reg [15:0] prev_word;
	reg [15:0] last_word;
	reg [1:0] nreads; // reads since this check began, held at 3
	reg tout_seen; // timeout bit seen while toggling
	reg busy;
	reg done;
	reg fail;
	reg susp;
	reg rstd;
	reg [15:0] read_count;
	reg [31:0] next_rdata;
	wire act_flip;
	wire sect_flip;
	wire data_match;

	assign act_flip = prev_word[`FSP_BIT_ACT] ^ last_word[`FSP_BIT_ACT];
	assign sect_flip = prev_word[`FSP_BIT_SECT] ^ last_word[`FSP_BIT_SECT];
	// Whole byte must match, because the top bit may settle before the rest within one read.
	assign data_match = (last_word[7:0] == expect_data);

	always @* begin
		case (reg_addr)
		`FSP_REG_CTRL: next_rdata = {30'd0, mode_poll, 1'b0};
		`FSP_REG_ADDR: next_rdata = {7'd0, poll_addr};
		`FSP_REG_STAT: next_rdata = {27'd0, rstd, susp, fail, done, busy};
		`FSP_REG_DATA: next_rdata = {16'd0, last_word};
		`FSP_REG_CNT: next_rdata = {16'd0, read_count};
		default: next_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
			state <= ST_IDLE;
			cnt <= 8'h00;
			mode_poll <= 1'b0;
			expect_data <= 8'h00;
			poll_addr <= 25'h000_0000;
			prev_word <= 16'h0000;
			last_word <= 16'h0000;
			nreads <= 2'd0;
			tout_seen <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			susp <= 1'b0;
			rstd <= 1'b0;
			read_count <= 16'h0000;
			flash_addr <= 25'h000_0000;
			flash_dq_out <= 16'h0000;
			flash_dq_oe <= 1'b0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
			if (reg_wr && reg_addr == `FSP_REG_ADDR && !busy)
				poll_addr <= reg_wdata[24:0];
			case (state)
			ST_IDLE: begin
				// Software starts polling only after its final command write is done.
				if (reg_wr && reg_addr == `FSP_REG_CTRL && reg_wdata[`FSP_CTRL_RESET]) begin
					flash_addr <= poll_addr;
					flash_dq_out <= `FSP_RESET_CMD;
					flash_dq_oe <= 1'b1;
					flash_ce_n <= 1'b0;
					flash_we_n <= 1'b0;
					cnt <= 8'h00;
					// Busy covers the command write so software cannot miss the reset-sent flag.
					busy <= 1'b1;
					state <= ST_WR;
				end else if (reg_wr && reg_addr == `FSP_REG_CTRL && reg_wdata[`FSP_CTRL_START]) begin
					mode_poll <= reg_wdata[`FSP_CTRL_MODE];
					expect_data <= reg_wdata[15:8];
					busy <= 1'b1;
					done <= 1'b0;
					fail <= 1'b0;
					susp <= 1'b0;
					rstd <= 1'b0;
					nreads <= 2'd0;
					tout_seen <= 1'b0;
					read_count <= 16'h0000;
					state <= ST_GAP;
					cnt <= 8'h00;
				end
			end
			ST_GAP: begin
				// Both enables stay high between reads so the toggle bits advance.
				flash_ce_n <= 1'b1;
				flash_oe_n <= 1'b1;
				if (cnt >= `FSP_GAP_CYC - 1) begin
					cnt <= 8'h00;
					flash_addr <= poll_addr;
					flash_ce_n <= 1'b0;
					flash_oe_n <= 1'b0;
					state <= ST_RD;
				end else
					cnt <= cnt + 8'h01;
			end
			ST_RD: begin
				if (cnt >= `FSP_RD_CYC - 1) begin
					cnt <= 8'h00;
					prev_word <= last_word;
					last_word <= flash_dq_in;
					read_count <= read_count + 16'h0001;
					if (nreads != 2'd3)
						nreads <= nreads + 2'd1;
					flash_ce_n <= 1'b1;
					flash_oe_n <= 1'b1;
					state <= ST_EVAL;
				end else
					cnt <= cnt + 8'h01;
			end
			ST_EVAL: begin
				state <= ST_GAP;
				if (mode_poll) begin
					// Erase reads 0 on the poll bit while busy, program its inverse; a match ends it.
					if (data_match) begin
						done <= 1'b1;
						busy <= 1'b0;
						state <= ST_FIN;
					end else if (last_word[`FSP_BIT_POLL] == expect_data[7] && !data_match) begin
						// Poll bit final but low bits not yet: read again.
						state <= ST_GAP;
					end else if (last_word[`FSP_BIT_TOUT]) begin
						if (tout_seen) begin
							fail <= 1'b1;
							busy <= 1'b0;
							state <= ST_FIN;
						end else
							tout_seen <= 1'b1;
					end
				end else if (nreads >= 2'd2) begin
					if (!act_flip) begin
						done <= 1'b1;
						busy <= 1'b0;
						// Sector bit still toggling with activity stopped means erase suspended.
						susp <= sect_flip;
						state <= ST_FIN;
					end else if (tout_seen) begin
						fail <= 1'b1;
						busy <= 1'b0;
						state <= ST_FIN;
					end else if (last_word[`FSP_BIT_TOUT])
						tout_seen <= 1'b1;
				end
			end
			ST_WR: begin
				if (cnt >= `FSP_RD_CYC - 1) begin
					cnt <= 8'h00;
					flash_we_n <= 1'b1;
					flash_ce_n <= 1'b1;
					flash_dq_oe <= 1'b0;
					state <= ST_FIN;
				end else
					cnt <= cnt + 8'h01;
				if (cnt >= `FSP_RD_CYC - 1) begin
					rstd <= 1'b1;
					busy <= 1'b0;
				end
			end
			ST_FIN: begin
				flash_dq_oe <= 1'b0;
				flash_ce_n <= 1'b1;
				flash_oe_n <= 1'b1;
				flash_we_n <= 1'b1;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // fsp_status_poller

// File: bench/fsp_flash_model.sv
// Flash model: status bits while busy, the programmed word after.
// Assumes reads bracketed by ce_n and oe_n from the poller.
`timescale 1ns/10ps
module fsp_flash_model (
	input wire flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, // strobes
	input wire [15:0] flash_dq_out, // command data
	input wire arm, err, // restart, never finish
	input wire [7:0] busy_rd, // busy reads
	input wire [15:0] word, // programmed word
	output wire [15:0] flash_dq_in // data out
);
	logic [7:0] n = 0;
	logic q = 0;
	logic [15:0] last = 0;
	wire busy = !q && (err || n <= busy_rd);
	wire [15:0] s = busy ? {word[15:8], ~word[7], n[0], err && n > 2, word[4:3], n[0], word[1:0]} : word;
	always @(negedge flash_oe_n or posedge arm)
		n <= arm ? 8'h00 : n + !flash_ce_n;
	// The delay lets the strobe's companion data settle first.
	always @(negedge flash_we_n or posedge arm)
		#1 q <= !arm && flash_dq_oe && flash_dq_out == 16'h00f0;
	always @(posedge flash_oe_n)
		last <= s;
	// A released bus shows the inverse of the last word, so a late sample cannot pass.
	assign flash_dq_in = !flash_ce_n && !flash_oe_n ? s : ~last;
endmodule // fsp_flash_model

// File: bench/fsp_status_poller_assertions.sv
// Checker of the poller's flash strobes and register read port.
// Assumes binding to fsp_status_poller, one clock domain.
`timescale 1ns/10ps
module fsp_status_poller_assertions (
	input wire clk, sys_rst, reg_rd, // clock, reset, read strobe
	input wire [3:0] reg_addr, // index
	input wire [31:0] reg_rdata, // read data
	input wire [24:0] flash_addr, // address
	input wire [15:0] flash_dq_out, // write data
	input wire flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n // strobes
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 0) else $error("stray rdata");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 4 |=> reg_rdata == 0) else $error("unmapped");
	a_read_len: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5] ##1 flash_oe_n) else $error("rd len");
	a_read_gap: assert property ($rose(flash_oe_n) |-> flash_oe_n [*3]) else $error("rd gap");
	a_read_pins: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe) else $error("pins");
	a_addr_held: assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr)) else $error("addr");
	a_reset_word: assert property (flash_dq_oe |-> !flash_we_n && flash_dq_out == 16'h00f0) else $error("cmd");
	a_write_len: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n) else $error("wr len");
	cover property ($fell(flash_oe_n));
	cover property ($fell(flash_we_n));
	cover property (reg_rd ##1 reg_rdata[2]);
endmodule // fsp_status_poller_assertions
bind fsp_status_poller fsp_status_poller_assertions i_chk (.clk, .sys_rst, .reg_rd, .reg_addr, .reg_rdata,
	.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n);

// File: bench/test_fsp_status_poller.sv
// Bench: table of status runs, then reset command and unmapped read.
// Assumes the behavioural flash model on the flash pins.
`timescale 1ns/10ps
`include "fsp_regs.vh"
module test_fsp_status_poller;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, arm = 0, err = 0, m;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, v;
	logic [7:0] busy_rd = 0;
	logic [15:0] word = 0;
	logic [2:0] x;
	wire [31:0] reg_rdata;
	wire [24:0] flash_addr;
	wire [15:0] flash_dq_out, flash_dq_in;
	wire flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
	int miscompares = 0, n_checks = 0, cyc = 0, k;
	logic [28:0] rows [6] = '{{1'h0, 8'h03, 1'h0, 16'h1234, 3'h2}, {1'h0, 8'h00, 1'h0, 16'h00ff, 3'h2},
		{1'h1, 8'h04, 1'h0, 16'h5a80, 3'h2}, {1'h1, 8'h02, 1'h0, 16'h00ff, 3'h2},
		{1'h0, 8'h05, 1'h1, 16'h0011, 3'h4}, {1'h1, 8'h05, 1'h1, 16'h0011, 3'h4}};
	always #10 clk = ~clk;
	fsp_status_poller i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_addr,
		.flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_oe_n, .flash_we_n);
	fsp_flash_model i_flash (.flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe, .flash_dq_out, .arm, .err,
		.busy_rd, .word, .flash_dq_in);
	task chk(input string what, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask
	// Bounded poll of the busy flag.
	task wait_idle;
		k = 0;
		do begin
			rd(`FSP_REG_STAT);
			k++;
		end while (v[0] !== 1'b0 && k < 300);
	endtask
	task complete_run;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			complete_run;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 0;
		#1 chk("pins", 32'h0000_000e, {flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe});
		foreach (rows[i]) begin
			{m, busy_rd, err, word, x} = rows[i];
			arm = 1;
			#1 arm = 0;
			wr(`FSP_REG_ADDR, i);
			wr(`FSP_REG_CTRL, {16'h0000, word[7:0], 6'h00, m, 1'h1});
			wait_idle;
			chk("status", {29'h0, x}, v & 32'h0000_0007);
			if (!err) begin
				rd(`FSP_REG_DATA);
				chk("data", {16'h0000, word}, v);
			end
			if (err) begin
				wr(`FSP_REG_CTRL, 32'h0000_0004);
				wait_idle;
				chk("reset sent", 32'h0000_0010, v & 32'h0000_0011);
			end
		end
		// Reset wins over a start written in the same word.
		wr(`FSP_REG_CTRL, 32'h0000_0005);
		wait_idle;
		chk("reset wins", 32'h0000_0010, v & 32'h0000_0011);
		rd(4'hf);
		chk("unmapped", 32'h0000_0000, v);
		complete_run;
	end
endmodule // test_fsp_status_poller
